// ### core/pcl_config_loader.sv
/*
   Fast passive parallel configuration loader: power-on delay, request
   handling, word capture at 8/16/32 bits, completion, init edges and
   hand-over of the data lines to user I/O.
   Assumes open-drain lines are resolved outside and the host follows the
   documented start-up order.
*/
`timescale 1ns/100ps
`include "pcl_defs.svh"
module pcl_config_loader #(
   parameter int POR_CYCLES  = `PCL_POR_CYCLES_DEF,
   parameter int IMAGE_BYTES = `PCL_IMAGE_BYTES_DEF
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rstn,
   // Host side pins
   input  wire logic        config_request_n,
   input  wire logic        config_clock,
   input  wire logic [1:0]  width_sel,
   input  wire logic [31:0] data_i,
   output logic [31:0]      data_o,
   output logic [31:0]      data_oe,
   // Open-drain status pins
   output logic             config_status_n_o,
   output logic             config_status_n_oe,
   output logic             config_complete_o,
   output logic             config_complete_oe,
   output logic             init_done_o,
   output logic             init_done_oe,
   // Fabric side
   output logic [31:0]      cfg_word,
   output logic             cfg_word_valid,
   output logic             user_mode,
   input  wire logic [31:0] user_data_out,
   input  wire logic [31:0] user_data_oe,
   output logic [31:0]      user_data_in
);
   localparam int PW = $clog2(POR_CYCLES + 1);
   localparam int CW = $clog2(IMAGE_BYTES + 8) + 1;
   localparam logic [PW-1:0] POR_LAST  = PW'(POR_CYCLES - 1);
   localparam logic [CW-1:0] IMG_BYTES = CW'(IMAGE_BYTES);

   // Image must end on a whole 32-bit word for every width
   initial begin
      if (POR_CYCLES < 1 || IMAGE_BYTES < 4 || (IMAGE_BYTES % 4) != 0)
         $error("pcl_config_loader: unsupported POR_CYCLES or IMAGE_BYTES");
   end

   pcl_pin_if pins ();

   pcl_pin_front u_front (
      .clock            (clock),
      .rstn             (rstn),
      .config_request_n (config_request_n),
      .config_clock     (config_clock),
      .width_sel        (width_sel),
      .data_i           (data_i),
      .pins             (pins)
   );

   // Bytes carried by one word of the given width
   function automatic logic [2:0] bytes_per_word(input pcl_pkg::pcl_width_t w);
      case (w)
         `PCL_WIDTH_X8:  bytes_per_word = `PCL_BYTES_X8;
         `PCL_WIDTH_X16: bytes_per_word = `PCL_BYTES_X16;
         default:        bytes_per_word = `PCL_BYTES_X32;
      endcase
   endfunction : bytes_per_word

   // Keep only the lanes of the selected width
   function automatic pcl_pkg::pcl_word_t lane_mask(input pcl_pkg::pcl_width_t w,
                                                    input pcl_pkg::pcl_word_t d);
      case (w)
         `PCL_WIDTH_X8:  lane_mask = d & `PCL_MASK_X8;
         `PCL_WIDTH_X16: lane_mask = d & `PCL_MASK_X16;
         default:        lane_mask = d & `PCL_MASK_X32;
      endcase
   endfunction : lane_mask

   pcl_pkg::pcl_state_e state,        next_state;
   logic [PW-1:0]       por_cnt,      next_por_cnt;
   logic [CW-1:0]       byte_cnt,     next_byte_cnt;
   pcl_pkg::pcl_width_t width,        next_width;
   logic [1:0]          fall_cnt,     next_fall_cnt;
   logic                status_oe,    next_status_oe;
   logic                complete_oe,  next_complete_oe;
   logic                init_oe,      next_init_oe;
   pcl_pkg::pcl_word_t  word,         next_word;
   logic                word_valid,   next_word_valid;
   logic [31:0]         io_o,         next_io_o;
   logic [31:0]         io_oe,        next_io_oe;
   logic [31:0]         io_in,        next_io_in;
   logic                in_user,      next_in_user;
   logic [CW-1:0]       byte_sum;
   logic                last_word;

   assign byte_sum  = byte_cnt + {{(CW-3){1'b0}}, bytes_per_word(width)};
   assign last_word = (byte_sum >= IMG_BYTES);

   // Sequencer and pin drive
   always_comb begin
      next_state       = state;
      next_por_cnt     = por_cnt;
      next_byte_cnt    = byte_cnt;
      next_width       = width;
      next_fall_cnt    = fall_cnt;
      next_status_oe   = status_oe;
      next_complete_oe = complete_oe;
      next_init_oe     = init_oe;
      next_word        = word;
      next_word_valid  = 1'b0;
      case (state)
         pcl_pkg::S_POR: begin
            next_status_oe   = 1'b1;
            next_complete_oe = 1'b1;
            next_por_cnt     = por_cnt + PW'(1);
            next_width       = pins.width;
            if (por_cnt == POR_LAST) begin
               next_state     = pins.req_n ? pcl_pkg::S_LOAD : pcl_pkg::S_RESET;
               next_status_oe = ~pins.req_n;
            end
         end
         pcl_pkg::S_RESET: begin
            next_byte_cnt = '0;
            next_fall_cnt = 2'h0;
            next_width    = pins.width;
            if (pins.req_n) begin
               next_state     = pcl_pkg::S_LOAD;
               next_status_oe = 1'b0;
            end
         end
         pcl_pkg::S_LOAD: begin
            // Word taken on the config clock's rising edge
            if (pins.clk_rise) begin
               next_word       = lane_mask(width, pins.data);
               next_word_valid = 1'b1;
               next_byte_cnt   = byte_sum;
               if (byte_cnt == '0 && pins.data[`PCL_OPT_INIT_DONE_BIT])
                  next_init_oe = 1'b1;
               // Complete released only once the image is whole
               if (last_word) begin
                  next_state       = pcl_pkg::S_INIT;
                  next_complete_oe = 1'b0;
               end
            end
         end
         pcl_pkg::S_INIT: begin
            if (pins.clk_fall) begin
               next_fall_cnt = fall_cnt + 2'h1;
               if (fall_cnt == `PCL_INIT_EDGES - 2'h1) begin
                  next_state   = pcl_pkg::S_USER;
                  next_init_oe = 1'b0;
               end
            end
         end
         pcl_pkg::S_USER: begin
            // Config clock deliberately not looked at here
            next_status_oe   = 1'b0;
            next_complete_oe = 1'b0;
         end
         default: begin
            next_state = pcl_pkg::S_RESET;
         end
      endcase
      // Request low restarts from any state but the power-on delay
      if (state != pcl_pkg::S_POR && !pins.req_n) begin
         next_state       = pcl_pkg::S_RESET;
         next_status_oe   = 1'b1;
         next_complete_oe = 1'b1;
         next_init_oe     = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state       <= pcl_pkg::S_POR;
         por_cnt     <= '0;
         byte_cnt    <= '0;
         width       <= `PCL_WIDTH_X8;
         fall_cnt    <= 2'h0;
         status_oe   <= 1'b1;
         complete_oe <= 1'b1;
         init_oe     <= 1'b0;
         word        <= 32'h0;
         word_valid  <= 1'b0;
      end else begin
         state       <= next_state;
         por_cnt     <= next_por_cnt;
         byte_cnt    <= next_byte_cnt;
         width       <= next_width;
         fall_cnt    <= next_fall_cnt;
         status_oe   <= next_status_oe;
         complete_oe <= next_complete_oe;
         init_oe     <= next_init_oe;
         word        <= next_word;
         word_valid  <= next_word_valid;
      end
   end

   // Data lines handed to the fabric only in user mode
   always_comb begin
      next_in_user = (next_state == pcl_pkg::S_USER);
      next_io_oe   = next_in_user ? user_data_oe  : 32'h0;
      next_io_o    = next_in_user ? user_data_out : 32'h0;
      next_io_in   = next_in_user ? pins.data     : 32'h0;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         io_o    <= 32'h0;
         io_oe   <= 32'h0;
         io_in   <= 32'h0;
         in_user <= 1'b0;
      end else begin
         io_o    <= next_io_o;
         io_oe   <= next_io_oe;
         io_in   <= next_io_in;
         in_user <= next_in_user;
      end
   end

   // Open-drain pins only ever pull low
   assign config_status_n_o  = 1'b0;
   assign config_complete_o  = 1'b0;
   assign init_done_o        = 1'b0;
   assign config_status_n_oe = status_oe;
   assign config_complete_oe = complete_oe;
   assign init_done_oe       = init_oe;
   assign data_o             = io_o;
   assign data_oe            = io_oe;
   assign cfg_word           = word;
   assign cfg_word_valid     = word_valid;
   assign user_mode          = in_user;
   assign user_data_in       = io_in;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence s_por_end;
      state == pcl_pkg::S_POR && por_cnt == POR_LAST && pins.req_n;
   endsequence
   sequence s_last_rise;
      state == pcl_pkg::S_LOAD && pins.clk_rise && pins.req_n && last_word;
   endsequence
   sequence s_second_fall;
      state == pcl_pkg::S_INIT && pins.clk_fall && pins.req_n && fall_cnt == 2'h1;
   endsequence

   a_por_status_low: assert property (state == pcl_pkg::S_POR |-> status_oe && complete_oe)
      else $error("status or complete released during power-on delay");
   a_por_release: assert property (s_por_end |=> !status_oe && state == pcl_pkg::S_LOAD)
      else $error("status not released after power-on delay");
   a_complete_low_load: assert property (state == pcl_pkg::S_LOAD |-> complete_oe)
      else $error("complete released before image end");
   a_user_lines_high: assert property (in_user |-> !status_oe && !complete_oe && !init_oe)
      else $error("a status line pulled low in user mode");
   a_clock_ignored: assert property (state == pcl_pkg::S_USER && pins.req_n
                                      |=> state == pcl_pkg::S_USER && !word_valid)
      else $error("config clock acted on after completion");
   a_lane_mask_x8: assert property (word_valid && width == `PCL_WIDTH_X8
                                     |-> word[31:8] == 24'h0)
      else $error("unused lanes captured in 8-bit mode");
   a_lane_mask_x16: assert property (word_valid && width == `PCL_WIDTH_X16
                                      |-> word[31:16] == 16'h0)
      else $error("unused lanes captured in 16-bit mode");
   a_word_capture: assert property (state == pcl_pkg::S_LOAD && pins.clk_rise && pins.req_n
                                     |=> word_valid && word == $past(lane_mask(width, pins.data)))
      else $error("rising edge did not capture a word");
   a_complete_release: assert property (s_last_rise |=> !complete_oe ##0 state == pcl_pkg::S_INIT)
      else $error("complete not released at image end");
   a_init_two_falls: assert property (s_second_fall |=> in_user ##1 !status_oe)
      else $error("user mode not entered after two falling edges");
   a_init_pin_low: assert property (state == pcl_pkg::S_LOAD && pins.clk_rise && pins.req_n
                                     && byte_cnt == '0 && pins.data[`PCL_OPT_INIT_DONE_BIT]
                                     |=> init_oe)
      else $error("init-done pin not driven low after option load");
   a_user_io: assert property (state == pcl_pkg::S_USER && pins.req_n
                                |=> data_oe == $past(user_data_oe) && data_o == $past(user_data_out))
      else $error("data lines not handed to user logic");
   a_restart: assert property (state != pcl_pkg::S_POR && !pins.req_n
                                |=> state == pcl_pkg::S_RESET && status_oe && complete_oe)
      else $error("request low did not restart configuration");
endmodule : pcl_config_loader

// ### core/pcl_defs.svh
/*
   Constants for the parallel configuration loader: width codes, option bit
   position, edge counts and default sizes.
   Assumes it is included by its bare name from the core/ folder.
*/
//
// Behaviour
// - In user mode the request, status and complete lines all sit high.
// - After power-up the status line is held low for the power-on delay and then released.
// - The complete line stays low from power-up until the whole image has been received.
// - Once configuration is complete, any activity on the configuration clock is ignored; here two falling edges after complete still lead into user mode.
// - Only the data lines of the selected width carry configuration data: 7..0, 15..0 or all 32.
// - After configuration the 32 data lines become user I/O under the fabric's control.
// - The complete line is released high only after every byte of the image has arrived.
// - Once the init-done option bit has been loaded from the image, the init-done pin is driven low.
`ifndef PCL_DEFS_SVH
`define PCL_DEFS_SVH

// Bus width strap codes
`define PCL_WIDTH_X8          2'h0
`define PCL_WIDTH_X16         2'h1
`define PCL_WIDTH_X32         2'h2

// Bytes per captured word
`define PCL_BYTES_X8          3'h1
`define PCL_BYTES_X16         3'h2
`define PCL_BYTES_X32         3'h4

// Data lane masks
`define PCL_MASK_X8           32'h0000_00ff
`define PCL_MASK_X16          32'h0000_ffff
`define PCL_MASK_X32          32'hffff_ffff

// Position of the init-done enable bit in the first image word
`define PCL_OPT_INIT_DONE_BIT 0

// Falling edges after complete that lead into user mode
`define PCL_INIT_EDGES        2'h2

// Default sizes; the power-on delay has no printed figure here
`define PCL_POR_CYCLES_DEF    256
`define PCL_IMAGE_BYTES_DEF   64

`endif

// ### core/pcl_pin_front.sv
/*
   Pin front end: two-flop synchronisers for every pin and edge detection
   of the configuration clock.
   Assumes the configuration clock is far slower than the core clock.
*/
`timescale 1ns/100ps
module pcl_pin_front (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rstn,
   // Raw pins
   input  wire logic        config_request_n,
   input  wire logic        config_clock,
   input  wire logic [1:0]  width_sel,
   input  wire logic [31:0] data_i,
   // Synchronised side
   pcl_pin_if.front         pins
);
   logic [1:0]  req_s,    next_req_s;
   logic [2:0]  clk_s,    next_clk_s;
   logic [1:0]  wid_s0,   next_wid_s0;
   logic [1:0]  wid_s1,   next_wid_s1;
   logic [31:0] dat_s0,   next_dat_s0;
   logic [31:0] dat_s1,   next_dat_s1;

   // Shift chains; third clock stage only feeds the edge compare
   always_comb begin
      next_req_s  = {req_s[0], config_request_n};
      next_clk_s  = {clk_s[1:0], config_clock};
      next_wid_s0 = width_sel;
      next_wid_s1 = wid_s0;
      next_dat_s0 = data_i;
      next_dat_s1 = dat_s0;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         req_s  <= 2'h0;
         clk_s  <= 3'h0;
         wid_s0 <= 2'h0;
         wid_s1 <= 2'h0;
         dat_s0 <= 32'h0;
         dat_s1 <= 32'h0;
      end else begin
         req_s  <= next_req_s;
         clk_s  <= next_clk_s;
         wid_s0 <= next_wid_s0;
         wid_s1 <= next_wid_s1;
         dat_s0 <= next_dat_s0;
         dat_s1 <= next_dat_s1;
      end
   end

   // Edges from second and third stages; data is of the same age
   assign pins.req_n    = req_s[1];
   assign pins.clk_rise = clk_s[1] & ~clk_s[2];
   assign pins.clk_fall = ~clk_s[1] & clk_s[2];
   assign pins.width    = wid_s1;
   assign pins.data     = dat_s1;
endmodule : pcl_pin_front

// ### core/pcl_pin_if.sv
/*
   Synchronised view of the configuration pins, passed from the pin front
   end to the loader core.
   Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface pcl_pin_if;
   logic                req_n;      // Request, synchronised
   logic                clk_rise;   // Config clock rising edge seen
   logic                clk_fall;   // Config clock falling edge seen
   pcl_pkg::pcl_width_t width;      // Width strap, synchronised
   pcl_pkg::pcl_word_t  data;       // Data lines, same age as the edges

   modport front (output req_n, output clk_rise, output clk_fall,
                  output width, output data);
   modport core  (input req_n, input clk_rise, input clk_fall,
                  input width, input data);
endinterface : pcl_pin_if

// ### core/pcl_pkg.sv
/*
   Types of the parallel configuration loader.
   Assumes the defs header supplies all numeric constants.
*/
package pcl_pkg;

   // Loader sequence
   typedef enum logic [2:0] {
      S_POR   = 3'h0,
      S_RESET = 3'h1,
      S_LOAD  = 3'h2,
      S_INIT  = 3'h3,
      S_USER  = 3'h4
   } pcl_state_e;

   typedef logic [31:0] pcl_word_t;
   typedef logic [1:0]  pcl_width_t;

endpackage : pcl_pkg

// ### test/pcl_host_model.sv
/*
   Host model for the parallel configuration loader: drives the request,
   the configuration clock and the data bus, as a small logic host would.
   Assumes the bench calls its tasks one at a time, on the core clock.
*/
`timescale 1ns/100ps
module pcl_host_model (
   // Core clock, used only for pacing
   input  wire logic        clock,
   // Host driven pins
   output logic             config_request_n,
   output logic             config_clock,
   output logic [31:0]      data_i,
   // Resolved open-drain complete line
   input  wire logic        config_complete
);
   // Idle: request high, config clock parked low, bus driven
   initial begin
      config_request_n = 1'b1;
      config_clock     = 1'b0;
      data_i           = 32'h0000_0000;
   end

   // Restart pulse, any time, user mode included
   task automatic request(input int cycles);
      @(posedge clock) config_request_n <= 1'b0;
      repeat (cycles) @(posedge clock);
      config_request_n <= 1'b1;
   endtask : request

   // One word per rising edge; 40 ns low, 50 ns high between calls, 90 ns per word
   task automatic send_word(input logic [31:0] w);
      @(posedge clock);
      config_clock <= 1'b0;
      data_i       <= w;
      repeat (4) @(posedge clock);
      config_clock <= 1'b1;
      @(posedge clock);
      data_i <= ~w; // Stale bits inverted once hold has run out
      repeat (3) @(posedge clock);
   endtask : send_word

   // Clock stays driven; ends high so a later word starts with a fall
   task automatic pulses(input int n);
      repeat (n) begin
         config_clock <= 1'b0;
         repeat (4) @(posedge clock);
         config_clock <= 1'b1;
         repeat (4) @(posedge clock);
      end
   endtask : pulses

   // Waits up to 200 cycles for complete high, then gives the two falls either way
   task automatic finish_init(output logic ok);
      ok = 1'b0;
      for (int n = 0; n < 200 && !ok; n++) begin
         @(posedge clock);
         ok = (config_complete === 1'b1);
      end
      pulses(2);
   endtask : finish_init

   // User mode traffic on the former data lines
   task automatic set_data(input logic [31:0] w);
      @(posedge clock) data_i <= w;
   endtask : set_data
endmodule : pcl_host_model

// ### test/test_pcl_config_loader.sv
/*
   Self-checking bench for the parallel configuration loader.
   Assumes shortened POR and image sizes; open-drain lines pulled up here.
*/
`timescale 1ns/100ps
module test_pcl_config_loader;
   localparam int POR_CYCLES  = 8;
   localparam int IMAGE_BYTES = 8;
   logic        clock, rstn, config_request_n, config_clock, config_complete;
   logic [1:0]  width_sel;
   logic [31:0] data_i, data_o, data_oe, cfg_word, user_data_out, user_data_oe, user_data_in;
   logic        status_oe, complete_oe, init_oe, cfg_word_valid, user_mode, ok;
   logic        status_n_o, complete_o, init_o, status_line, init_line;
   logic [31:0] got_q[$];
   int          num_errors, compares;

   // Device under test
   pcl_config_loader #(.POR_CYCLES(POR_CYCLES), .IMAGE_BYTES(IMAGE_BYTES)) pcl_config_loader_i (
      .clock(clock), .rstn(rstn), .config_request_n(config_request_n),
      .config_clock(config_clock), .width_sel(width_sel), .data_i(data_i),
      .data_o(data_o), .data_oe(data_oe), .config_status_n_o(status_n_o),
      .config_status_n_oe(status_oe), .config_complete_o(complete_o),
      .config_complete_oe(complete_oe), .init_done_o(init_o), .init_done_oe(init_oe),
      .cfg_word(cfg_word), .cfg_word_valid(cfg_word_valid), .user_mode(user_mode),
      .user_data_out(user_data_out), .user_data_oe(user_data_oe),
      .user_data_in(user_data_in));

   // Host at the far side
   pcl_host_model pcl_host_model_i (
      .clock(clock), .config_request_n(config_request_n), .config_clock(config_clock),
      .data_i(data_i), .config_complete(config_complete));

   // Pull-ups on the open-drain lines; a driven line shows the device's level
   assign config_complete = complete_oe ? complete_o : 1'b1;
   assign status_line     = status_oe ? status_n_o : 1'b1;
   assign init_line       = init_oe ? init_o : 1'b1;

   initial clock = 1'b0;
   always #5 clock = ~clock;

   // Every captured word, in order
   always @(posedge clock) begin
      if (cfg_word_valid === 1'b1) got_q.push_back(cfg_word);
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Let the edge's updates land before looking
   task automatic settle(input int n);
      repeat (n) @(negedge clock);
   endtask : settle

   task automatic results;
      $display("Comparisons %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : results

   task automatic t_power_up;
      settle(4);
      chk("status_oe in por", 32'h1, status_oe);
      chk("complete_oe in por", 32'h1, complete_oe);
      chk("status line in por", 32'h0, status_line);
      chk("complete line in por", 32'h0, config_complete);
      settle(POR_CYCLES + 8);
      chk("status_oe after por", 32'h0, status_oe);
      chk("complete_oe idle", 32'h1, complete_oe);
   endtask : t_power_up

   // Full x32 image, init edges, user mode, then clock noise
   task automatic t_load_x32;
      got_q.delete();
      pcl_host_model_i.send_word(32'hc3a5_0f01);
      settle(4);
      chk("init_oe after option", 32'h1, init_oe);
      chk("init line after option", 32'h0, init_line);
      chk("complete_oe mid image", 32'h1, complete_oe);
      pcl_host_model_i.send_word(32'h8765_4321);
      settle(4);
      chk("complete_oe after image", 32'h0, complete_oe);
      chk("user_mode before falls", 32'h0, user_mode);
      chk("x32 words", 32'h2, got_q.size());
      chk("x32 word 0", 32'hc3a5_0f01, got_q[0]);
      chk("x32 word 1", 32'h8765_4321, got_q[1]);
      pcl_host_model_i.finish_init(ok);
      settle(4);
      chk("complete seen", 32'h1, {31'h0, ok});
      chk("status line user", 32'h1, status_line);
      chk("complete line user", 32'h1, config_complete);
      chk("init line user", 32'h1, init_line);
      chk("user_mode", 32'h1, user_mode);
      chk("status_oe user", 32'h0, status_oe);
      chk("complete_oe user", 32'h0, complete_oe);
      chk("init_oe user", 32'h0, init_oe);
      chk("data_oe user", user_data_oe, data_oe);
      chk("data_o user", user_data_out, data_o);
      // Fabric changes its drive; the pins must follow
      @(posedge clock);
      user_data_out <= 32'h0f1e_2d3c;
      user_data_oe  <= 32'hf0f0_0f0f;
      settle(4);
      chk("data_o user new", 32'h0f1e_2d3c, data_o);
      chk("data_oe user new", 32'hf0f0_0f0f, data_oe);
      pcl_host_model_i.set_data(32'h1234_abcd);
      settle(8);
      chk("user_data_in", 32'h1234_abcd, user_data_in);
      pcl_host_model_i.pulses(3);
      settle(6);
      chk("words after user", 32'h2, got_q.size());
      chk("user_mode kept", 32'h1, user_mode);
   endtask : t_load_x32

   // Restart from user mode, x8, image cut short
   task automatic t_partial_x8;
      logic [7:0] b;
      @(posedge clock) width_sel <= 2'h0;
      pcl_host_model_i.request(8);
      settle(1);
      chk("status_oe restart", 32'h1, status_oe);
      chk("complete_oe restart", 32'h1, complete_oe);
      chk("user_mode restart", 32'h0, user_mode);
      chk("data_oe restart", 32'h0, data_oe);
      settle(8);
      chk("status_oe released", 32'h0, status_oe);
      got_q.delete();
      for (b = 8'h0; b < 8'h4; b++) begin
         pcl_host_model_i.send_word({24'hfe_dcba, 8'h10 + b * 8'h22});
      end
      settle(8);
      chk("complete_oe partial", 32'h1, complete_oe);
      chk("init_oe bit clear", 32'h0, init_oe);
      chk("x8 words", 32'h4, got_q.size());
      for (int i = 0; i < 4; i++) begin
         chk("x8 word", {24'h0, 8'h10 + 8'(i) * 8'h22}, got_q[i]);
      end
   endtask : t_partial_x8

   // Restart mid image, complete x16 image
   task automatic t_load_x16;
      logic [7:0] b;
      @(posedge clock) width_sel <= 2'h1;
      pcl_host_model_i.request(8);
      settle(8);
      got_q.delete();
      for (b = 8'h0; b < 8'h4; b++) begin
         // Look off the edge so the compare never races the flop update
         if (b == 8'h3) begin
            settle(1);
            chk("complete_oe 6 bytes", 32'h1, complete_oe);
         end
         pcl_host_model_i.send_word({16'h5a5a, 8'h77, b});
      end
      settle(4);
      chk("complete_oe x16", 32'h0, complete_oe);
      chk("x16 words", 32'h4, got_q.size());
      chk("x16 word 3", 32'h0000_7703, got_q[3]);
      pcl_host_model_i.finish_init(ok);
      settle(4);
      chk("user_mode x16", 32'h1, user_mode);
      chk("status_oe x16", 32'h0, status_oe);
   endtask : t_load_x16

   // Main sequence
   initial begin
      rstn          = 1'b0;
      width_sel     = 2'h2;
      user_data_out = 32'h5a5a_00ff;
      user_data_oe  = 32'h0000_ffff;
      num_errors    = 0;
      compares      = 0;
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      t_power_up();
      t_load_x32();
      t_partial_x8();
      t_load_x16();
      results();
   end

   // Hang guard, well past the expected run
   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      $display("[ERR] watchdog expected end seen timeout");
      results();
   end
endmodule : test_pcl_config_loader
